// *** tcgr_pkg.sv ***
package tcgr_pkg;

	// Timecode value in BCD-free binary fields
	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
	} tcgr_tc_s;

	// Frame rate: drop-frame flag and highest frame number
	typedef struct packed {
		logic drop;
		logic [4:0] last_frame;
	} tcgr_rate_s;

	// Timecode modes, one-hot
	typedef enum logic [6:0] {
		TCGR_REC_GATED = 7'h01,
		TCGR_FREE_RUN = 7'h02,
		TCGR_CLOCK_LOCKED = 7'h04,
		TCGR_FOLLOW_STOP = 7'h08,
		TCGR_FOLLOW_AUTO = 7'h10,
		TCGR_FOLLOW_KEEP = 7'h20,
		TCGR_FOLLOW_AUTO_KEEP = 7'h40
	} tcgr_mode_e;

	// Automatic record sequencer
	typedef enum logic [2:0] {
		TCGR_AR_IDLE = 3'h1,
		TCGR_AR_HOLD = 3'h2,
		TCGR_AR_REC = 3'h4
	} tcgr_ar_e;

	localparam logic [4:0] TCGR_LAST_HOUR = 5'h17;
	localparam logic [5:0] TCGR_LAST_MINSEC = 6'h3B;
	localparam logic [4:0] TCGR_DF_FIRST_FRAME = 5'h02;
	localparam logic [4:0] TCGR_ND_FIRST_FRAME = 5'h00;
	localparam logic [5:0] TCGR_DF_KEEP_MINUTES = 6'h0A;
	// Frame ticks without incoming frames before the input counts as lost
	localparam logic [2:0] TCGR_LOSS_FRAMES = 3'h2;
	localparam tcgr_tc_s TCGR_TC_RESET = '0;
	localparam logic [31:0] TCGR_UBITS_RESET = 32'h0000_0000;

endpackage

// *** tcgr_tc_inc.sv ***
`timescale 1ns/1ps
module tcgr_tc_inc (
	// Current value and rate
	input wire tcgr_pkg::tcgr_tc_s tc_in,
	input wire tcgr_pkg::tcgr_rate_s rate,
	// Value one frame later
	output tcgr_pkg::tcgr_tc_s tc_out
);

	always_comb begin
		tc_out = tc_in;
		if (tc_in.frames >= rate.last_frame) begin
			tc_out.frames = 5'h00;
			if (tc_in.seconds >= tcgr_pkg::TCGR_LAST_MINSEC) begin
				tc_out.seconds = 6'h00;
				if (tc_in.minutes >= tcgr_pkg::TCGR_LAST_MINSEC) begin
					tc_out.minutes = 6'h00;
					tc_out.hours = (tc_in.hours >= tcgr_pkg::TCGR_LAST_HOUR) ? 5'h00 : tc_in.hours + 5'h01;
				end else begin
					tc_out.minutes = tc_in.minutes + 6'h01;
				end
				// Frames 00 and 01 skipped at each new minute but every tenth
				if (rate.drop && (tc_out.minutes % tcgr_pkg::TCGR_DF_KEEP_MINUTES) != 6'h00) begin
					tc_out.frames = tcgr_pkg::TCGR_DF_FIRST_FRAME;
				end
			end else begin
				tc_out.seconds = tc_in.seconds + 6'h01;
			end
		end else begin
			tc_out.frames = tc_in.frames + 5'h01;
		end
	end

endmodule // tcgr_tc_inc

// *** tcgr_core.sv ***
// How it works
// - Record-gated mode advances only while recording or while a file is still open, otherwise holds the value.
// - Record-gated restores held value at power-up and freezes on mode entry.
// - Free run advances always; loadable by jam or manual preset.
// - Clock-locked runs always, loaded from time-of-day on entry and time change.
// - Stop-on-loss readers track input, stop on loss; recording manual only.
// - Keep-running readers track input and count on alone after loss.
// - Auto-record readers start on advancing input, stop when input stops.
// - Auto-record waits a settle delay; shorter bursts never trigger.
// - Settle delay applies only in the two auto-record modes.
// - Pre-roll reaches back to first detection; without it file starts at the start of the second of expiry.
// - Files start on frame 0 (02 drop-frame), end on frame 0.
// - Playback outputs file start stamp advanced at configured rate.
// - Jam copies incoming value and user bits; cancelling changes nothing.
// - Flag incoming rate differing from configured rate, showing both.
// - Present frame difference between generator and incoming timecode.
// - User bits loadable manually, independent of jam.
`timescale 1ns/1ps
module tcgr_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration
	input wire tcgr_pkg::tcgr_mode_e mode,
	input wire tcgr_pkg::tcgr_rate_s rate,
	input wire logic [7:0] holdoff_frames,
	input wire logic preroll_en,
	input wire tcgr_pkg::tcgr_tc_s held_tc,
	// Frame timing
	input wire logic frame_tick,
	// Incoming timecode
	input wire logic ext_stb,
	input wire tcgr_pkg::tcgr_tc_s follow_input_stop_on_loss,
	input wire logic [31:0] ext_ubits,
	input wire tcgr_pkg::tcgr_rate_s ext_rate,
	// User commands
	input wire logic jam_cmd,
	input wire logic preset_stb,
	input wire tcgr_pkg::tcgr_tc_s preset_tc,
	input wire logic ubits_stb,
	input wire logic [31:0] ubits_preset,
	input wire logic tod_stb,
	input wire tcgr_pkg::tcgr_tc_s tod_tc,
	input wire logic rec_start,
	input wire logic rec_stop,
	// Playback
	input wire logic play_active,
	input wire logic play_load,
	input wire tcgr_pkg::tcgr_tc_s play_stamp,
	// Timecode out
	output tcgr_pkg::tcgr_tc_s tc_out_q,
	output logic [31:0] ubits_q,
	// Recording
	output logic rec_active_q,
	output logic file_open_q,
	output logic [8:0] preroll_frames_q,
	// Monitoring
	output logic mismatch_q,
	output tcgr_pkg::tcgr_rate_s ext_rate_q,
	output logic signed [24:0] diff_q
);

	tcgr_pkg::tcgr_tc_s gen_q, gen_d, gen_inc, play_q, play_d, play_inc, ext_last_q, ext_last_d, tc_out_d;
	logic [31:0] ubits_d, ext_ubits_q, ext_ubits_d;
	logic init_done_q, init_done_d;
	tcgr_pkg::tcgr_mode_e mode_prev_q;
	logic ext_present_q, ext_present_d, ext_running_q, ext_running_d;
	logic [2:0] loss_cnt_q, loss_cnt_d;
	logic reader, auto_mode, keep_mode, advance;

	tcgr_pkg::tcgr_ar_e ar_q, ar_d;
	logic [7:0] hold_cnt_q, hold_cnt_d;
	logic man_rec_q, man_rec_d, rec_active_d, file_open_d;
	logic [8:0] preroll_d;
	logic [4:0] start_frame;
	logic [5:0] align, fps, back_mod, det_align;
	logic [7:0] back_frames;

	logic mismatch_d;
	tcgr_pkg::tcgr_rate_s ext_rate_d;
	logic signed [24:0] diff_d;
	logic [16:0] sod_gen, sod_ext;

	tcgr_tc_inc u_gen_inc (
		.tc_in(gen_q),
		.rate(rate),
		.tc_out(gen_inc)
	);

	tcgr_tc_inc u_play_inc (
		.tc_in(play_q),
		.rate(rate),
		.tc_out(play_inc)
	);

	assign reader = mode inside {tcgr_pkg::TCGR_FOLLOW_STOP, tcgr_pkg::TCGR_FOLLOW_AUTO,
		tcgr_pkg::TCGR_FOLLOW_KEEP, tcgr_pkg::TCGR_FOLLOW_AUTO_KEEP};
	assign auto_mode = mode inside {tcgr_pkg::TCGR_FOLLOW_AUTO, tcgr_pkg::TCGR_FOLLOW_AUTO_KEEP};
	assign keep_mode = mode inside {tcgr_pkg::TCGR_FOLLOW_KEEP, tcgr_pkg::TCGR_FOLLOW_AUTO_KEEP};

	// Generator, user bits, input tracking and playback
	always_comb begin
		unique case (mode)
			tcgr_pkg::TCGR_REC_GATED: advance = rec_active_q | file_open_q;
			tcgr_pkg::TCGR_FREE_RUN: advance = 1'b1;
			tcgr_pkg::TCGR_CLOCK_LOCKED: advance = 1'b1;
			tcgr_pkg::TCGR_FOLLOW_KEEP, tcgr_pkg::TCGR_FOLLOW_AUTO_KEEP: advance = ~ext_present_q;
			default: advance = 1'b0;
		endcase
		init_done_d = 1'b1;
		gen_d = gen_q;
		ubits_d = ubits_q;
		if (!init_done_q) begin
			gen_d = held_tc;
		end else if (jam_cmd) begin
			gen_d = ext_last_q;
			ubits_d = ext_ubits_q;
		end else if (preset_stb) begin
			gen_d = preset_tc;
		end else if (mode == tcgr_pkg::TCGR_CLOCK_LOCKED && (mode_prev_q != mode || tod_stb)) begin
			gen_d = tod_tc;
		end else if (reader && ext_stb) begin
			gen_d = follow_input_stop_on_loss;
		end else if (frame_tick && advance) begin
			gen_d = gen_inc;
		end
		if (ubits_stb && !jam_cmd) begin
			ubits_d = ubits_preset;
		end
		ext_last_d = ext_stb ? follow_input_stop_on_loss : ext_last_q;
		ext_ubits_d = ext_stb ? ext_ubits : ext_ubits_q;
		ext_present_d = ext_present_q;
		loss_cnt_d = loss_cnt_q;
		ext_running_d = ext_running_q;
		if (ext_stb) begin
			ext_present_d = 1'b1;
			loss_cnt_d = 3'h0;
			ext_running_d = (follow_input_stop_on_loss != ext_last_q);
		end else if (frame_tick && ext_present_q) begin
			loss_cnt_d = loss_cnt_q + 3'h1;
			if (loss_cnt_d >= tcgr_pkg::TCGR_LOSS_FRAMES) begin
				ext_present_d = 1'b0;
				ext_running_d = 1'b0;
			end
		end
		play_d = play_q;
		if (play_load) begin
			play_d = play_stamp;
		end else if (play_active && frame_tick) begin
			play_d = play_inc;
		end
		tc_out_d = play_active ? play_d : gen_d;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gen_q <= tcgr_pkg::TCGR_TC_RESET;
			ubits_q <= tcgr_pkg::TCGR_UBITS_RESET;
			init_done_q <= 1'b0;
			mode_prev_q <= tcgr_pkg::TCGR_REC_GATED;
			ext_last_q <= tcgr_pkg::TCGR_TC_RESET;
			ext_ubits_q <= tcgr_pkg::TCGR_UBITS_RESET;
			ext_present_q <= 1'b0;
			ext_running_q <= 1'b0;
			loss_cnt_q <= 3'h0;
			play_q <= tcgr_pkg::TCGR_TC_RESET;
			tc_out_q <= tcgr_pkg::TCGR_TC_RESET;
		end else begin
			gen_q <= gen_d;
			ubits_q <= ubits_d;
			init_done_q <= init_done_d;
			mode_prev_q <= mode;
			ext_last_q <= ext_last_d;
			ext_ubits_q <= ext_ubits_d;
			ext_present_q <= ext_present_d;
			ext_running_q <= ext_running_d;
			loss_cnt_q <= loss_cnt_d;
			play_q <= play_d;
			tc_out_q <= tc_out_d;
		end
	end

	// Recording control and whole-second file framing
	always_comb begin
		ar_d = ar_q;
		hold_cnt_d = hold_cnt_q;
		if (!auto_mode) begin
			ar_d = tcgr_pkg::TCGR_AR_IDLE;
			hold_cnt_d = 8'h00;
		end else begin
			unique case (ar_q)
				tcgr_pkg::TCGR_AR_IDLE: begin
					hold_cnt_d = 8'h00;
					if (ext_running_q) begin
						ar_d = tcgr_pkg::TCGR_AR_HOLD;
					end
				end
				tcgr_pkg::TCGR_AR_HOLD: begin
					if (!ext_running_q) begin
						ar_d = tcgr_pkg::TCGR_AR_IDLE;
					end else if (hold_cnt_q >= holdoff_frames) begin
						ar_d = tcgr_pkg::TCGR_AR_REC;
					end else if (frame_tick) begin
						hold_cnt_d = hold_cnt_q + 8'h01;
					end
				end
				tcgr_pkg::TCGR_AR_REC: begin
					if (!ext_running_q) begin
						ar_d = tcgr_pkg::TCGR_AR_IDLE;
					end
				end
				default: ar_d = tcgr_pkg::TCGR_AR_IDLE;
			endcase
		end
		man_rec_d = man_rec_q;
		if (auto_mode) begin
			man_rec_d = 1'b0;
		end else if (rec_stop) begin
			man_rec_d = 1'b0;
		end else if (rec_start) begin
			man_rec_d = 1'b1;
		end
		rec_active_d = auto_mode ? (ar_d == tcgr_pkg::TCGR_AR_REC) : man_rec_d;
		start_frame = rate.drop ? tcgr_pkg::TCGR_DF_FIRST_FRAME : tcgr_pkg::TCGR_ND_FIRST_FRAME;
		if (gen_q.frames >= start_frame) begin
			align = {1'b0, gen_q.frames - start_frame};
		end else begin
			align = {1'b0, gen_q.frames} + {1'b0, rate.last_frame} + 6'h01 - {1'b0, start_frame};
		end
		// Reach back to first detection if enabled, then to the start of that second
		back_frames = (auto_mode && preroll_en) ? hold_cnt_q : 8'h00;
		fps = {1'b0, rate.last_frame} + 6'h01;
		back_mod = 6'(back_frames % {2'h0, fps});
		if (align >= back_mod) begin
			det_align = align - back_mod;
		end else begin
			det_align = align + fps - back_mod;
		end
		file_open_d = file_open_q;
		preroll_d = preroll_frames_q;
		if (!file_open_q && rec_active_d) begin
			file_open_d = 1'b1;
			preroll_d = {1'b0, back_frames} + {3'h0, det_align};
		end else if (file_open_q && !rec_active_d && frame_tick && gen_d.frames == 5'h00) begin
			file_open_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ar_q <= tcgr_pkg::TCGR_AR_IDLE;
			hold_cnt_q <= 8'h00;
			man_rec_q <= 1'b0;
			rec_active_q <= 1'b0;
			file_open_q <= 1'b0;
			preroll_frames_q <= 9'h000;
		end else begin
			ar_q <= ar_d;
			hold_cnt_q <= hold_cnt_d;
			man_rec_q <= man_rec_d;
			rec_active_q <= rec_active_d;
			file_open_q <= file_open_d;
			preroll_frames_q <= preroll_d;
		end
	end

	// Rate mismatch and drift monitor
	always_comb begin
		mismatch_d = mismatch_q;
		ext_rate_d = ext_rate_q;
		if (ext_stb) begin
			mismatch_d = (ext_rate != rate);
			ext_rate_d = ext_rate;
		end
		sod_gen = 17'(gen_q.hours) * 17'd3600 + 17'(gen_q.minutes) * 17'd60 + 17'(gen_q.seconds);
		sod_ext = 17'(ext_last_q.hours) * 17'd3600 + 17'(ext_last_q.minutes) * 17'd60 + 17'(ext_last_q.seconds);
		diff_d = (25'(sod_gen) - 25'(sod_ext)) * (25'(rate.last_frame) + 25'sd1)
			+ 25'(gen_q.frames) - 25'(ext_last_q.frames);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mismatch_q <= 1'b0;
			ext_rate_q <= '0;
			diff_q <= 25'sd0;
		end else begin
			mismatch_q <= mismatch_d;
			ext_rate_q <= ext_rate_d;
			diff_q <= diff_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	gate_hold_a: assert property (mode == tcgr_pkg::TCGR_REC_GATED && init_done_q && !rec_active_q && !file_open_q
		&& !jam_cmd && !preset_stb |=> gen_q == $past(gen_q)) else $error("gated generator moved while idle");
	powerup_a: assert property ($rose(init_done_q) |-> gen_q == $past(held_tc))
		else $error("held value not restored");
	free_adv_a: assert property (mode == tcgr_pkg::TCGR_FREE_RUN && init_done_q && frame_tick
		&& !jam_cmd && !preset_stb |=> gen_q == $past(gen_inc)) else $error("free run did not advance");
	tod_load_a: assert property (mode == tcgr_pkg::TCGR_CLOCK_LOCKED && init_done_q && tod_stb
		&& !jam_cmd && !preset_stb |=> gen_q == $past(tod_tc)) else $error("time of day not loaded");
	stop_loss_a: assert property (mode == tcgr_pkg::TCGR_FOLLOW_STOP && init_done_q && !ext_stb
		&& !jam_cmd && !preset_stb |=> gen_q == $past(gen_q)) else $error("generator moved without input");
	holdoff_a: assert property (ar_q == tcgr_pkg::TCGR_AR_HOLD ##1 ar_q == tcgr_pkg::TCGR_AR_REC
		|-> $past(hold_cnt_q) >= $past(holdoff_frames) && rec_active_q) else $error("record before settle");
	no_auto_a: assert property (!auto_mode |=> ar_q == tcgr_pkg::TCGR_AR_IDLE)
		else $error("settle delay outside auto modes");
	jam_copy_a: assert property (init_done_q && jam_cmd |=> gen_q == $past(ext_last_q)
		&& ubits_q == $past(ext_ubits_q)) else $error("jam did not copy input");
	file_end_a: assert property ($fell(file_open_q) |-> gen_q.frames == 5'h00)
		else $error("file closed off frame zero");
	mismatch_a: assert property (ext_stb |=> mismatch_q == ($past(ext_rate) != $past(rate)))
		else $error("rate mismatch flag wrong");

endmodule // tcgr_core

// *** tcgr_src_model.sv ***
`timescale 1ns/1ps
module tcgr_src_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control from the bench
	input wire logic frame_tick,
	input wire logic present,
	input wire logic run,
	input wire logic src_load,
	input wire tcgr_pkg::tcgr_tc_s ld_tc,
	input wire logic [31:0] sub,
	input wire tcgr_pkg::tcgr_rate_s srate,
	// Decoded incoming frames
	output logic ext_stb,
	output tcgr_pkg::tcgr_tc_s follow_input_stop_on_loss,
	output logic [31:0] ext_ubits,
	output tcgr_pkg::tcgr_rate_s ext_rate
);
	tcgr_pkg::tcgr_tc_s cur;
	logic wrap;
	assign wrap = cur.frames == srate.last_frame;
	// Counts frames and seconds only; scenarios never cross a minute
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur <= '0;
			ext_stb <= 1'b0;
			follow_input_stop_on_loss <= '0;
			ext_ubits <= '0;
			ext_rate <= '0;
		end else begin
			ext_stb <= present & frame_tick;
			if (src_load)
				cur <= ld_tc;
			else if (present & frame_tick & run) begin
				cur.frames <= wrap ? 5'h00 : cur.frames + 5'h01;
				cur.seconds <= cur.seconds + {5'h00, wrap};
			end
			if (present & frame_tick) begin
				follow_input_stop_on_loss <= cur;
				ext_ubits <= sub;
				ext_rate <= srate;
			end else if (!present) begin
				// Released input shows a changing pattern
				follow_input_stop_on_loss <= ~follow_input_stop_on_loss;
				ext_ubits <= ~ext_ubits;
			end
		end
	end
endmodule // tcgr_src_model

// *** tcgr_core_test.sv ***
`timescale 1ns/1ps
module tcgr_core_test;
	typedef struct packed {
		tcgr_pkg::tcgr_rate_s r;
		tcgr_pkg::tcgr_tc_s p;
		tcgr_pkg::tcgr_tc_s e;
	} tcgr_row_s;
	localparam tcgr_pkg::tcgr_rate_s r23 = '{1'b0, 5'h17};
	localparam tcgr_pkg::tcgr_rate_s r24 = '{1'b0, 5'h18};
	localparam tcgr_pkg::tcgr_rate_s d29 = '{1'b1, 5'h1D};
	logic clk = 1'b0, rstn = 1'b0, preroll_en = 1'b0, play_active = 1'b0;
	logic present = 1'b0, run = 1'b0, rec_seen = 1'b0;
	tcgr_pkg::tcgr_mode_e mode = tcgr_pkg::TCGR_FREE_RUN;
	tcgr_pkg::tcgr_rate_s rate = r23, srate = r23, ext_rate, ext_rate_q;
	logic [7:0] holdoff_frames = 8'h00;
	logic [8:0] sv = '0;
	logic [8:0] preroll_frames_q;
	logic [31:0] sub = '0, ubits_preset = '0, ext_ubits, ubits_q;
	tcgr_pkg::tcgr_tc_s held_tc = '0, preset_tc = '0, tod_tc = '0, play_stamp = '0, ld_tc = '0;
	tcgr_pkg::tcgr_tc_s v, tc_out_q, follow_input_stop_on_loss;
	logic rec_active_q, file_open_q, mismatch_q, ext_stb;
	logic signed [24:0] diff_q;
	tcgr_row_s rows [6];
	int fail_count = 0, check_count = 0;
	wire logic jam_cmd = sv[0], preset_stb = sv[1], ubits_stb = sv[2], tod_stb = sv[3];
	wire logic rec_start = sv[4], rec_stop = sv[5], play_load = sv[6], frame_tick = sv[7], src_load = sv[8];

	tcgr_core dut_u (.clk, .rstn, .mode, .rate, .holdoff_frames, .preroll_en, .held_tc, .frame_tick,
		.ext_stb, .follow_input_stop_on_loss, .ext_ubits, .ext_rate, .jam_cmd, .preset_stb, .preset_tc, .ubits_stb,
		.ubits_preset, .tod_stb, .tod_tc, .rec_start, .rec_stop, .play_active, .play_load, .play_stamp,
		.tc_out_q, .ubits_q, .rec_active_q, .file_open_q, .preroll_frames_q, .mismatch_q, .ext_rate_q, .diff_q);
	tcgr_src_model src_u (.clk, .rstn, .frame_tick, .present, .run, .src_load, .ld_tc, .sub, .srate,
		.ext_stb, .follow_input_stop_on_loss, .ext_ubits, .ext_rate);

	always #25 clk = ~clk;
	always @(posedge clk) if (rec_active_q === 1'b1) rec_seen <= 1'b1;

	function automatic tcgr_pkg::tcgr_tc_s mk(logic [4:0] h, logic [5:0] m, logic [5:0] s, logic [4:0] f);
		return '{h, m, s, f};
	endfunction
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic pulse(int b);
		@(posedge clk) sv[b] <= 1'b1;
		@(posedge clk) sv <= '0;
		#1;
	endtask
	task automatic tick(int n);
		repeat (n) begin
			pulse(7);
			repeat (3) @(posedge clk);
			#1;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		rows[0] = '{r23, mk(5'h00, 6'h00, 6'h00, 5'h17), mk(5'h00, 6'h00, 6'h01, 5'h00)};
		rows[1] = '{r23, mk(5'h00, 6'h00, 6'h3B, 5'h17), mk(5'h00, 6'h01, 6'h00, 5'h00)};
		rows[2] = '{r23, mk(5'h17, 6'h3B, 6'h3B, 5'h17), mk(5'h00, 6'h00, 6'h00, 5'h00)};
		rows[3] = '{r24, mk(5'h01, 6'h02, 6'h03, 5'h04), mk(5'h01, 6'h02, 6'h03, 5'h05)};
		rows[4] = '{d29, mk(5'h00, 6'h00, 6'h3B, 5'h1D), mk(5'h00, 6'h01, 6'h00, 5'h02)};
		rows[5] = '{d29, mk(5'h00, 6'h09, 6'h3B, 5'h1D), mk(5'h00, 6'h0A, 6'h00, 5'h00)};
		held_tc = mk(5'h01, 6'h02, 6'h03, 5'h04);
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk) rate <= rows[i].r;
			preset_tc <= rows[i].p;
			pulse(1);
			chk("preset", tc_out_q, rows[i].p);
			tick(1);
			chk("advance", tc_out_q, rows[i].e);
		end
		// Mid-run reset into the record-gated generator
		@(posedge clk) mode <= tcgr_pkg::TCGR_REC_GATED;
		rate <= r23;
		rstn <= 1'b0;
		#1 chk("reset", tc_out_q, 32'h0);
		@(posedge clk) rstn <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("restore", tc_out_q, held_tc);
		tick(2);
		chk("gated hold", tc_out_q, held_tc);
		pulse(4);
		chk("rec", rec_active_q, 1'b1);
		chk("preroll align", preroll_frames_q, 9'h004);
		tick(1);
		chk("gated run", tc_out_q.frames, 5'h05);
		pulse(5);
		chk("rec stop", rec_active_q, 1'b0);
		for (int n = 0; n < 40 && file_open_q === 1'b1; n++) tick(1);
		chk("file end", {file_open_q, tc_out_q.frames}, 6'h00);
		@(posedge clk) mode <= tcgr_pkg::TCGR_FREE_RUN;
		ld_tc <= mk(5'h02, 6'h00, 6'h00, 5'h05);
		sub <= 32'hA5A5_0F0F;
		srate <= r24;
		present <= 1'b1;
		pulse(8);
		tick(1);
		chk("mismatch", mismatch_q, 1'b1);
		chk("ext rate", ext_rate_q, r24);
		pulse(0);
		chk("jam tc", tc_out_q, ld_tc);
		chk("jam ubits", ubits_q, 32'hA5A5_0F0F);
		repeat (2) @(posedge clk);
		#1 chk("diff", diff_q, 32'h0);
		tick(1);
		chk("drift", diff_q, 32'h1);
		@(posedge clk) ubits_preset <= 32'h1234_5678;
		pulse(2);
		chk("ubits", ubits_q, 32'h1234_5678);
		@(posedge clk) srate <= r23;
		tick(1);
		chk("rate ok", mismatch_q, 1'b0);
		@(posedge clk) tod_tc <= mk(5'h0A, 6'h00, 6'h00, 5'h00);
		mode <= tcgr_pkg::TCGR_CLOCK_LOCKED;
		repeat (2) @(posedge clk);
		#1 chk("tod entry", tc_out_q, tod_tc);
		@(posedge clk) tod_tc <= mk(5'h0B, 6'h01, 6'h00, 5'h00);
		pulse(3);
		chk("tod set", tc_out_q, tod_tc);
		tick(1);
		chk("tod run", tc_out_q, mk(5'h0B, 6'h01, 6'h00, 5'h01));
		@(posedge clk) play_stamp <= mk(5'h03, 6'h04, 6'h05, 5'h06);
		play_active <= 1'b1;
		pulse(6);
		chk("play", tc_out_q, play_stamp);
		tick(1);
		chk("play run", tc_out_q, mk(5'h03, 6'h04, 6'h05, 5'h07));
		@(posedge clk) play_active <= 1'b0;
		mode <= tcgr_pkg::TCGR_FOLLOW_STOP;
		ld_tc <= '0;
		run <= 1'b1;
		rec_seen <= 1'b0;
		pulse(8);
		tick(4);
		chk("follow", tc_out_q, follow_input_stop_on_loss);
		@(posedge clk) present <= 1'b0;
		tick(3);
		v = tc_out_q;
		tick(2);
		chk("stop on loss", tc_out_q, v);
		chk("no auto rec", rec_seen, 1'b0);
		@(posedge clk) mode <= tcgr_pkg::TCGR_FOLLOW_KEEP;
		present <= 1'b1;
		pulse(8);
		tick(3);
		@(posedge clk) present <= 1'b0;
		tick(3);
		v = tc_out_q;
		v.frames = v.frames + 5'h02;
		tick(2);
		chk("keep running", tc_out_q, v);
		@(posedge clk) mode <= tcgr_pkg::TCGR_FOLLOW_AUTO;
		holdoff_frames <= 8'h04;
		preroll_en <= 1'b1;
		present <= 1'b1;
		rec_seen <= 1'b0;
		tick(1);
		@(posedge clk) run <= 1'b0;
		tick(3);
		chk("short burst", rec_seen, 1'b0);
		@(posedge clk) run <= 1'b1;
		tick(10);
		chk("auto rec", rec_active_q, 1'b1);
		chk("preroll", preroll_frames_q, 9'h008);
		@(posedge clk) run <= 1'b0;
		tick(3);
		chk("auto stop", rec_active_q, 1'b0);
		@(posedge clk) mode <= tcgr_pkg::TCGR_FOLLOW_AUTO_KEEP;
		present <= 1'b0;
		tick(3);
		v = tc_out_q;
		v.frames = v.frames + 5'h02;
		tick(2);
		chk("auto keep", tc_out_q, v);
		tally_and_finish();
	end
endmodule // tcgr_core_test
